// file: src/amp_cfg.svh
// amp_cfg.svh: offsets, field positions, reset values and timing counts
// of the amplifier status and mode block; definitions only
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH

// register offsets on the control port
`define AMP_OFS_MISC_CTRL1 8'h01
`define AMP_OFS_STATE_REQ 8'h04
`define AMP_OFS_WARN_CLEAR 8'h21
`define AMP_OFS_FAULT_MASK 8'h22
`define AMP_OFS_WARN_MASK 8'h23
`define AMP_OFS_STATUS 8'h24
`define AMP_OFS_CH_STATUS 8'h25

// field positions
`define AMP_BIT_CLEAR 7
`define AMP_BIT_ILIMIT_LVL 4
`define AMP_FLD_OTW_LO 5
`define AMP_FLD_OTW_HI 6
`define AMP_BIT_FM_CHAN 0
`define AMP_BIT_FM_TSD 1
`define AMP_BIT_FM_VOLT 2
`define AMP_BIT_FM_CLK 3
`define AMP_BIT_WM_CLIP 0
`define AMP_BIT_WM_OTW 1

// state request codes
`define AMP_REQ_HIZ 2'h0
`define AMP_REQ_MUTE 2'h1
`define AMP_REQ_PLAY 2'h2

// reset values
`define AMP_RST_MISC_CTRL1 8'h00
`define AMP_RST_FAULT_MASK 4'h0
`define AMP_RST_WARN_MASK 2'h0
`define AMP_RST_STATE_REQ 2'h0

// timing and channel count
`define AMP_CLK_PERIOD_NS 50
`define AMP_RAMP_TIME_NS 5000000
`define AMP_CLIP_PERIODS 20
`define AMP_NUM_CH 4

`endif

// file: src/amp_clip_det.sv
// amp_clip_det: one channel's clip detector, counts pwm periods at full modulation
// assumes pwmTick is a one-cycle pulse per pwm period on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_clip_det
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// modulation status
	input wire logic pwmTick,
	input wire logic maxMod,
	// result
	output logic clipHit
);

	localparam logic [4:0] CLIP_LAST = 5'(`AMP_CLIP_PERIODS - 1);

	logic [4:0] runCnt_reg;
	logic [4:0] runCnt_next;
	logic clipHit_reg;
	logic clipHit_next;

	always_comb
	begin
		runCnt_next = runCnt_reg;
		clipHit_next = 1'b0;
		if (!maxMod)
		begin
			runCnt_next = 5'h00;
		end
		else if (pwmTick)
		begin
			// pulse once when the run reaches its length, then hold the count
			if (runCnt_reg == CLIP_LAST)
			begin
				clipHit_next = 1'b1;
			end
			if (runCnt_reg <= CLIP_LAST)
			begin
				runCnt_next = runCnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			runCnt_reg <= 5'h00;
			clipHit_reg <= 1'b0;
		end
		else
		begin
			runCnt_reg <= runCnt_next;
			clipHit_reg <= clipHit_next;
		end
	end

	assign clipHit = clipHit_reg;

endmodule
`default_nettype wire

// file: src/amp_pkg.sv
// amp_pkg: types of the amplifier status and mode block
// assumes amp_cfg.svh is compiled alongside for constants
package amp_pkg;

	typedef enum logic [2:0]
	{
		AMP_ST_STANDBY,
		AMP_ST_HIZ,
		AMP_ST_MUTE,
		AMP_ST_PLAY,
		AMP_ST_RAMP
	} amp_state_t;

endpackage

// file: src/amp_status_ctrl.sv
// amp_status_ctrl: fault and warning pins, mute and standby pins, operating state,
// fault actions and the registers behind the control port
// assumes a serial control engine that issues one-cycle writes and samples read data
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

// Operation
// - fault pin low while channel, thermal shutdown, supply or clock fault present
// - fault pin released high once no fault condition remains
// - fault masks gate only the pin; status and protection unchanged
// - all fault categories unmasked after reset
// - warning pin low for clipping, overtemperature warning or power-on reset
// - clip flagged after 20 consecutive pwm periods at full modulation
// - clip status sticky, cleared by writing one to bit 7 at 0x21
// - warning pin latched until bit 7 at 0x21 is written
// - overtemperature warning when global or any channel warning set
// - warning threshold taken from bits 6:5 of register 0x01
// - clip and overtemperature masks gate only the warning pin, unmasked at reset
// - mute pin low mutes all channels, release unmutes
// - standby pin low shuts down, ramping outputs within 5 ms
// - standby stops oscillator, outputs Hi-Z, control port released
// - Hi-Z keeps oscillator and control port, outputs high impedance
// - mute switches at 50%, play with audio, oscillator and port active
// - power-on reset reported as warning and forces standby in every mode
// - supply low or high reported on fault pin, forces Hi-Z outside standby
// - overtemperature warning reported on warning pin, no output change
// - thermal shutdown reported on fault pin, forces outputs Hi-Z
// - current limit in mute and play limits, not reported as fault
// - channel overcurrent or dc error reported, that channel forced Hi-Z
// - clip latch combines all channels into one warning
module amp_status_ctrl
	import amp_pkg::*;
#(
	// margin covers the pin synchroniser and output registers, so the whole ramp stays inside its limit
	parameter int RAMP_CYCLES = (`AMP_RAMP_TIME_NS / `AMP_CLK_PERIOD_NS) - 8
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// control pins, asynchronous
	input wire logic mutePinN,
	input wire logic standbyPinN,
	// status pins, open drain
	output logic faultPinOut,
	output logic faultPinOe,
	output logic warnPinOut,
	output logic warnPinOe,
	// monitor inputs from analog and pwm logic on clk_sys
	input wire logic [`AMP_NUM_CH-1:0] chOverCurrent,
	input wire logic [`AMP_NUM_CH-1:0] chDcError,
	input wire logic [`AMP_NUM_CH-1:0] chCurLimitHit,
	input wire logic [`AMP_NUM_CH-1:0] chThermalShutdown,
	input wire logic [`AMP_NUM_CH-1:0] chOverTempWarning,
	input wire logic [`AMP_NUM_CH-1:0] chMaxMod,
	input wire logic pwmTick,
	input wire logic overTempWarning,
	input wire logic thermalShutdownEvent,
	input wire logic lowSupplyEvent,
	input wire logic highSupplyEvent,
	input wire logic clockError,
	input wire logic porEvent,
	// control port register access
	input wire logic regWr,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	// output stage and core control
	output logic [`AMP_NUM_CH-1:0] chHiZ,
	output logic [`AMP_NUM_CH-1:0] chCurLimitEn,
	output logic outMute50,
	output logic outAudio,
	output logic outRampDown,
	output logic oscEnable,
	output logic ctrlPortEnable,
	output logic iLimitLevel,
	output logic [1:0] otwThreshold
);

	localparam int RAMP_W = $clog2(RAMP_CYCLES + 1);
	localparam logic [RAMP_W-1:0] RAMP_LAST = RAMP_W'(RAMP_CYCLES);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and clip detectors

	logic [1:0] pinSync;
	logic muteSyncN;
	logic standbySyncN;
	logic [`AMP_NUM_CH-1:0] chClipHit;

	amp_sync2 #(.WIDTH(2), .RST_VAL(2'h0)) u_pinSync
	(
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.asyncIn({mutePinN, standbyPinN}),
		.syncOut(pinSync)
	);

	assign muteSyncN = pinSync[1];
	assign standbySyncN = pinSync[0];

	genvar ch;
	generate
		for (ch = 0; ch < `AMP_NUM_CH; ch++)
		begin : g_clip
			amp_clip_det u_clip
			(
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.pwmTick(pwmTick),
				.maxMod(chMaxMod[ch]),
				.clipHit(chClipHit[ch])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// operating state

	amp_state_t state_reg;
	amp_state_t state_next;
	logic [RAMP_W-1:0] rampCnt_reg;
	logic [RAMP_W-1:0] rampCnt_next;
	logic [1:0] stateReq_reg;
	logic running;

	always_comb
	begin
		state_next = state_reg;
		rampCnt_next = rampCnt_reg;
		if (porEvent)
		begin
			state_next = AMP_ST_STANDBY;
		end
		else
		begin
			case (state_reg)
				AMP_ST_STANDBY:
				begin
					if (standbySyncN)
					begin
						state_next = AMP_ST_HIZ;
					end
				end
				AMP_ST_RAMP:
				begin
					// the ramp is not abandoned on standby release, so the stage always ends quiet
					if (rampCnt_reg == RAMP_LAST)
					begin
						state_next = AMP_ST_STANDBY;
					end
					rampCnt_next = rampCnt_reg + RAMP_W'(1);
				end
				default:
				begin
					if (!standbySyncN)
					begin
						rampCnt_next = '0;
						if (state_reg == AMP_ST_HIZ)
						begin
							state_next = AMP_ST_STANDBY;
						end
						else
						begin
							state_next = AMP_ST_RAMP;
						end
					end
					else if (stateReq_reg == `AMP_REQ_HIZ)
					begin
						state_next = AMP_ST_HIZ;
					end
					else if (!muteSyncN || stateReq_reg == `AMP_REQ_MUTE)
					begin
						state_next = AMP_ST_MUTE;
					end
					else
					begin
						state_next = AMP_ST_PLAY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= AMP_ST_STANDBY;
			rampCnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			rampCnt_reg <= rampCnt_next;
		end
	end

	assign running = (state_reg == AMP_ST_MUTE) || (state_reg == AMP_ST_PLAY) || (state_reg == AMP_ST_RAMP);

	////////////////////////////////////////////////////////////////////////////////
	// fault and warning conditions

	logic voltFault;
	logic tsdFault;
	logic [`AMP_NUM_CH-1:0] chFault;
	logic anyOtw;
	logic anyClip;
	logic monitoring;
	logic [3:0] faultMask_reg;
	logic [1:0] warnMask_reg;
	logic clearWrite;

	// supplies and temperature are watched whenever the core is awake
	assign monitoring = (state_reg != AMP_ST_STANDBY);
	assign voltFault = monitoring && (lowSupplyEvent || highSupplyEvent);
	assign tsdFault = monitoring && thermalShutdownEvent;
	assign chFault = running ? (chOverCurrent | chDcError) : '0;
	assign anyOtw = overTempWarning || (|chOverTempWarning);
	assign anyClip = |chClipHit;
	assign clearWrite = regWr && ctrlPortEnable && (regAddr == `AMP_OFS_WARN_CLEAR) && regWrData[`AMP_BIT_CLEAR];

	////////////////////////////////////////////////////////////////////////////////
	// sticky status and pins

	logic clipSticky_reg;
	logic clipSticky_next;
	logic otwSticky_reg;
	logic otwSticky_next;
	logic porSticky_reg;
	logic porSticky_next;
	logic warnLatch_reg;
	logic warnLatch_next;
	logic faultPin_reg;
	logic faultPin_next;
	logic warnSet;

	// a new event in the clearing cycle wins over the clear
	assign warnSet = (anyClip && !warnMask_reg[`AMP_BIT_WM_CLIP])
		|| (anyOtw && !warnMask_reg[`AMP_BIT_WM_OTW])
		|| porEvent;

	always_comb
	begin
		clipSticky_next = anyClip || (clipSticky_reg && !clearWrite);
		otwSticky_next = anyOtw || (otwSticky_reg && !clearWrite);
		porSticky_next = porEvent || (porSticky_reg && !clearWrite);
		warnLatch_next = warnSet || (warnLatch_reg && !clearWrite);
		faultPin_next = ((|chFault) && !faultMask_reg[`AMP_BIT_FM_CHAN])
			|| (tsdFault && !faultMask_reg[`AMP_BIT_FM_TSD])
			|| (voltFault && !faultMask_reg[`AMP_BIT_FM_VOLT])
			|| (clockError && !faultMask_reg[`AMP_BIT_FM_CLK]);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			clipSticky_reg <= 1'b0;
			otwSticky_reg <= 1'b0;
			porSticky_reg <= 1'b1;
			warnLatch_reg <= 1'b1;
			faultPin_reg <= 1'b0;
		end
		else
		begin
			clipSticky_reg <= clipSticky_next;
			otwSticky_reg <= otwSticky_next;
			porSticky_reg <= porSticky_next;
			warnLatch_reg <= warnLatch_next;
			faultPin_reg <= faultPin_next;
		end
	end

	assign faultPinOut = 1'b0;
	assign faultPinOe = faultPin_reg;
	assign warnPinOut = 1'b0;
	assign warnPinOe = warnLatch_reg;

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0] miscCtrl_reg;
	logic [7:0] miscCtrl_next;
	logic [3:0] faultMask_next;
	logic [1:0] warnMask_next;
	logic [1:0] stateReq_next;
	logic [7:0] rdData_reg;
	logic [7:0] rdData_next;
	logic wrOk;

	// the port is released in standby, so writes there are dropped
	assign wrOk = regWr && ctrlPortEnable;

	always_comb
	begin
		miscCtrl_next = miscCtrl_reg;
		faultMask_next = faultMask_reg;
		warnMask_next = warnMask_reg;
		stateReq_next = stateReq_reg;
		if (wrOk)
		begin
			if (regAddr == `AMP_OFS_MISC_CTRL1)
			begin
				miscCtrl_next = regWrData;
			end
			else if (regAddr == `AMP_OFS_STATE_REQ)
			begin
				stateReq_next = regWrData[1:0];
			end
			else if (regAddr == `AMP_OFS_FAULT_MASK)
			begin
				faultMask_next = regWrData[3:0];
			end
			else if (regAddr == `AMP_OFS_WARN_MASK)
			begin
				warnMask_next = regWrData[1:0];
			end
		end
		if (regAddr == `AMP_OFS_MISC_CTRL1)
		begin
			rdData_next = miscCtrl_reg;
		end
		else if (regAddr == `AMP_OFS_STATE_REQ)
		begin
			rdData_next = {6'h00, stateReq_reg};
		end
		else if (regAddr == `AMP_OFS_FAULT_MASK)
		begin
			rdData_next = {4'h0, faultMask_reg};
		end
		else if (regAddr == `AMP_OFS_WARN_MASK)
		begin
			rdData_next = {6'h00, warnMask_reg};
		end
		else if (regAddr == `AMP_OFS_STATUS)
		begin
			// fault conditions and sticky flags unmasked; bit 0 is the warning latch, which follows the warning masks
			rdData_next = {clockError, voltFault, tsdFault, |chFault,
				porSticky_reg, otwSticky_reg, clipSticky_reg, warnLatch_reg};
		end
		else if (regAddr == `AMP_OFS_CH_STATUS)
		begin
			rdData_next = {chOverTempWarning, chFault};
		end
		else
		begin
			rdData_next = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			miscCtrl_reg <= `AMP_RST_MISC_CTRL1;
			faultMask_reg <= `AMP_RST_FAULT_MASK;
			warnMask_reg <= `AMP_RST_WARN_MASK;
			stateReq_reg <= `AMP_RST_STATE_REQ;
			rdData_reg <= 8'h00;
		end
		else
		begin
			miscCtrl_reg <= miscCtrl_next;
			faultMask_reg <= faultMask_next;
			warnMask_reg <= warnMask_next;
			stateReq_reg <= stateReq_next;
			rdData_reg <= rdData_next;
		end
	end

	assign regRdData = rdData_reg;
	assign iLimitLevel = miscCtrl_reg[`AMP_BIT_ILIMIT_LVL];
	assign otwThreshold = miscCtrl_reg[`AMP_FLD_OTW_HI:`AMP_FLD_OTW_LO];

	////////////////////////////////////////////////////////////////////////////////
	// output stage controls

	logic [`AMP_NUM_CH-1:0] chHiZ_reg;
	logic [`AMP_NUM_CH-1:0] chHiZ_next;
	logic [`AMP_NUM_CH-1:0] curLim_reg;
	logic [`AMP_NUM_CH-1:0] curLim_next;
	logic [4:0] outCtl_reg;
	logic [4:0] outCtl_next;
	logic globalHiZ;
	logic [`AMP_NUM_CH-1:0] chTsdHiZ;

	// overtemperature warning and clipping deliberately take no part here
	assign globalHiZ = voltFault || tsdFault || !running;
	// a hot channel is parked alone while the others keep playing
	assign chTsdHiZ = monitoring ? chThermalShutdown : '0;

	always_comb
	begin
		chHiZ_next = {`AMP_NUM_CH{globalHiZ}} | chFault | chTsdHiZ;
		curLim_next = running ? chCurLimitHit : '0;
		outCtl_next[0] = (state_reg == AMP_ST_MUTE) && !globalHiZ;
		outCtl_next[1] = (state_reg == AMP_ST_PLAY) && !globalHiZ;
		outCtl_next[2] = (state_reg == AMP_ST_RAMP);
		outCtl_next[3] = (state_reg != AMP_ST_STANDBY);
		outCtl_next[4] = (state_reg != AMP_ST_STANDBY);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			chHiZ_reg <= '1;
			curLim_reg <= '0;
			outCtl_reg <= 5'h00;
		end
		else
		begin
			chHiZ_reg <= chHiZ_next;
			curLim_reg <= curLim_next;
			outCtl_reg <= outCtl_next;
		end
	end

	assign chHiZ = chHiZ_reg;
	assign chCurLimitEn = curLim_reg;
	assign outMute50 = outCtl_reg[0];
	assign outAudio = outCtl_reg[1];
	assign outRampDown = outCtl_reg[2];
	assign oscEnable = outCtl_reg[3];
	assign ctrlPortEnable = outCtl_reg[4];

endmodule
`default_nettype wire

// file: src/amp_sync2.sv
// amp_sync2: two flip-flop synchroniser for asynchronous pin levels
// assumes the inputs are static levels; a pulse shorter than one clock may be missed
`timescale 1ns/1ps
`default_nettype none

module amp_sync2
#(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '1
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// levels
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			stage1_reg <= RST_VAL;
			stage2_reg <= RST_VAL;
		end
		else
		begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
		end
	end

	assign syncOut = stage2_reg;

endmodule
`default_nettype wire

// file: testbench/amp_host_model.sv
// amp_host_model: host side of the status and control pins
// assumes open-drain status pins with pull-ups and push-pull host outputs
`timescale 1ns/1ps
`default_nettype none

module amp_host_model
(
	// status pins
	input wire logic faultPinOut,
	input wire logic faultPinOe,
	input wire logic warnPinOut,
	input wire logic warnPinOe,
	output logic faultLineN,
	output logic warnLineN,
	// control pins
	input wire logic muteReq,
	input wire logic standbyReq,
	output logic mutePinN,
	output logic standbyPinN
);
	// released line reads the pull-up level, never the last driven value
	assign faultLineN = faultPinOe ? faultPinOut : 1'b1;
	assign warnLineN = warnPinOe ? warnPinOut : 1'b1;
	assign mutePinN = !muteReq;
	assign standbyPinN = !standbyReq;
endmodule
`default_nettype wire

// file: testbench/amp_status_ctrl_bench.sv
// amp_status_ctrl_bench: directed register and pin sequences
// assumes amp_cfg.svh on the include path; ramp count shortened to 20
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_status_ctrl_bench;
	import amp_pkg::*;
	localparam int RAMP = 20;
	logic clk_sys, sys_rst, muteReq, standbyReq, mutePinN, standbyPinN, faultLineN, warnLineN;
	logic faultPinOut, faultPinOe, warnPinOut, warnPinOe, pwmTick, overTempWarning, thermalShutdownEvent;
	logic lowSupplyEvent, highSupplyEvent, clockError, porEvent, regWr, outMute50, outAudio, outRampDown;
	logic oscEnable, ctrlPortEnable, iLimitLevel;
	logic [3:0] chOverCurrent, chDcError, chCurLimitHit, chOverTempWarning, chMaxMod, chHiZ, chCurLimitEn;
	logic [3:0] chThermalShutdown;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [1:0] otwThreshold;
	int num_errors, n_tests, i;
	////////////////////////////////////////////////////////////////
	amp_status_ctrl #(.RAMP_CYCLES(RAMP)) amp_status_ctrl_inst (.clk_sys, .sys_rst, .mutePinN, .standbyPinN,
		.faultPinOut, .faultPinOe, .warnPinOut, .warnPinOe, .chOverCurrent, .chDcError, .chCurLimitHit,
		.chThermalShutdown, .chOverTempWarning, .chMaxMod, .pwmTick, .overTempWarning,
		.thermalShutdownEvent, .lowSupplyEvent, .highSupplyEvent, .clockError, .porEvent, .regWr, .regAddr,
		.regWrData, .regRdData, .chHiZ, .chCurLimitEn, .outMute50, .outAudio, .outRampDown, .oscEnable,
		.ctrlPortEnable, .iLimitLevel, .otwThreshold);
	amp_host_model amp_host_model_inst (.faultPinOut, .faultPinOe, .warnPinOut, .warnPinOe, .faultLineN,
		.warnLineN, .muteReq, .standbyReq, .mutePinN, .standbyPinN);
	always #25 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want)
		begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, want);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		regWr = 1'b1;
		regAddr = a;
		regWrData = d;
		cyc(1);
		regWr = 1'b0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a);
		regAddr = a;
		cyc(1);
	endtask
	task tick(input int n);
		repeat (n)
		begin
			pwmTick = 1'b1;
			cyc(1);
			pwmTick = 1'b0;
			cyc(2);
		end
	endtask
	// 4 and 5 are second members of the channel and supply categories
	task src(input int k, input logic v);
		case (k)
			0: chOverCurrent[0] = v;
			1: thermalShutdownEvent = v;
			2: lowSupplyEvent = v;
			3: clockError = v;
			4: chDcError[0] = v;
			default: highSupplyEvent = v;
		endcase
		cyc(3);
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// the whole sequence needs about 400 cycles; allow more than ten times that
	initial
	begin
		#1000000;
		num_errors++;
		conclude;
	end
	initial
	begin
		{clk_sys, muteReq, standbyReq, pwmTick, overTempWarning, thermalShutdownEvent, lowSupplyEvent} = '0;
		{highSupplyEvent, clockError, porEvent, regWr, regAddr, regWrData, i, num_errors, n_tests} = '0;
		{chOverCurrent, chDcError, chCurLimitHit, chOverTempWarning, chMaxMod, chThermalShutdown} = '0;
		sys_rst = 1'b1;
		cyc(20);
		chk(warnLineN, 1'b0);
		chk(chHiZ, 4'hF);
		sys_rst = 1'b0;
		cyc(6);
		chk(ctrlPortEnable, 1'b1);
		rd(`AMP_OFS_FAULT_MASK);
		chk(regRdData, 8'h00);
		rd(`AMP_OFS_WARN_MASK);
		chk(regRdData, 8'h00);
		rd(8'h7F);
		chk(regRdData, 8'h00);
		wr(`AMP_OFS_WARN_CLEAR, 8'h80);
		chk(warnLineN, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			wr(`AMP_OFS_MISC_CTRL1, {1'b0, i[1:0], 5'h10});
			chk(otwThreshold, i[1:0]);
			chk(iLimitLevel, 1'b1);
		end
		done("reset and registers");
		wr(`AMP_OFS_STATE_REQ, 8'h02);
		cyc(3);
		chk(outAudio, 1'b1);
		for (i = 0; i < 6; i++)
		begin
			src(i, 1'b1);
			chk(faultLineN, 1'b0);
			src(i, 1'b0);
			chk(faultLineN, 1'b1);
			wr(`AMP_OFS_FAULT_MASK, 8'h01 << (i == 5 ? 2 : i % 4));
			src(i, 1'b1);
			chk(faultLineN, 1'b1);
			rd(`AMP_OFS_STATUS);
			chk(regRdData[4 + (i == 5 ? 2 : i % 4)], 1'b1);
			src(i, 1'b0);
			wr(`AMP_OFS_FAULT_MASK, 8'h00);
			wr(`AMP_OFS_STATE_REQ, 8'h02);
			cyc(3);
		end
		chCurLimitHit = 4'hA;
		cyc(3);
		chk(faultLineN, 1'b1);
		chk(chCurLimitEn, 4'hA);
		chCurLimitHit = 4'h0;
		chThermalShutdown = 4'h2;
		cyc(3);
		chk(chHiZ, 4'h2);
		chThermalShutdown = 4'h0;
		cyc(3);
		chk(chHiZ, 4'h0);
		done("faults");
		chMaxMod = 4'h4;
		tick(19);
		chk(warnLineN, 1'b1);
		tick(1);
		chk(warnLineN, 1'b0);
		chMaxMod = 4'h0;
		cyc(3);
		chk(warnLineN, 1'b0);
		chk(outAudio, 1'b1);
		rd(`AMP_OFS_STATUS);
		chk(regRdData[1], 1'b1);
		wr(`AMP_OFS_WARN_CLEAR, 8'h80);
		chk(warnLineN, 1'b1);
		rd(`AMP_OFS_STATUS);
		chk(regRdData[1], 1'b0);
		wr(`AMP_OFS_WARN_MASK, 8'h01);
		chMaxMod = 4'h1;
		tick(21);
		chMaxMod = 4'h0;
		chk(warnLineN, 1'b1);
		rd(`AMP_OFS_STATUS);
		chk(regRdData[1], 1'b1);
		chOverTempWarning = 4'h8;
		cyc(3);
		chk(warnLineN, 1'b0);
		chk(outAudio, 1'b1);
		chOverTempWarning = 4'h0;
		wr(`AMP_OFS_WARN_CLEAR, 8'h80);
		wr(`AMP_OFS_WARN_MASK, 8'h02);
		overTempWarning = 1'b1;
		cyc(3);
		chk(warnLineN, 1'b1);
		rd(`AMP_OFS_STATUS);
		chk(regRdData[2], 1'b1);
		overTempWarning = 1'b0;
		wr(`AMP_OFS_WARN_CLEAR, 8'h80);
		wr(`AMP_OFS_WARN_MASK, 8'h00);
		done("warnings");
		muteReq = 1'b1;
		cyc(6);
		chk({outMute50, outAudio}, 2'h2);
		muteReq = 1'b0;
		cyc(6);
		chk(outAudio, 1'b1);
		standbyReq = 1'b1;
		cyc(5);
		chk(outRampDown, 1'b1);
		cyc(RAMP + 4);
		chk({oscEnable, ctrlPortEnable, chHiZ}, 6'h0F);
		wr(`AMP_OFS_MISC_CTRL1, 8'h00);
		standbyReq = 1'b0;
		cyc(8);
		rd(`AMP_OFS_MISC_CTRL1);
		chk(regRdData, 8'h70);
		done("mute and standby");
		porEvent = 1'b1;
		cyc(1);
		porEvent = 1'b0;
		cyc(1);
		chk({warnLineN, ctrlPortEnable}, 2'h0);
		cyc(10);
		rd(`AMP_OFS_STATUS);
		chk(regRdData[3], 1'b1);
		done("power-on event");
		conclude;
	end
endmodule
`default_nettype wire

// file: testbench/amp_status_ctrl_props.sv
// amp_status_ctrl_props: port assertions for the status and mode block
// assumes binding into amp_status_ctrl; amp_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "amp_cfg.svh"

module amp_status_ctrl_props
#(
	parameter int RAMP_CYCLES = 20
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// pins
	input wire logic mutePinN,
	input wire logic standbyPinN,
	input wire logic faultPinOe,
	input wire logic warnPinOe,
	// monitors
	input wire logic [`AMP_NUM_CH-1:0] chOverCurrent,
	input wire logic [`AMP_NUM_CH-1:0] chDcError,
	input wire logic [`AMP_NUM_CH-1:0] chOverTempWarning,
	input wire logic [`AMP_NUM_CH-1:0] chMaxMod,
	input wire logic overTempWarning,
	input wire logic thermalShutdownEvent,
	input wire logic lowSupplyEvent,
	input wire logic highSupplyEvent,
	input wire logic clockError,
	input wire logic porEvent,
	// register port
	input wire logic regWr,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	// outputs
	input wire logic [`AMP_NUM_CH-1:0] chHiZ,
	input wire logic outMute50,
	input wire logic outAudio,
	input wire logic oscEnable,
	input wire logic ctrlPortEnable,
	input wire logic [1:0] otwThreshold
);
	localparam int RAMP_MAX = RAMP_CYCLES + 6;
	logic [3:0] fMask_reg, fMask_next, cause;
	int rampCnt_reg, rampCnt_next;
	logic wrOk, clrWr;
	////////////////////////////////////////////////////////////////
	// shadow of the fault mask, so masked categories are not expected on the pin
	assign wrOk = regWr && ctrlPortEnable;
	assign clrWr = wrOk && regAddr == `AMP_OFS_WARN_CLEAR && regWrData[`AMP_BIT_CLEAR];
	assign cause = {clockError, lowSupplyEvent || highSupplyEvent, thermalShutdownEvent, |(chOverCurrent | chDcError)};
	always_comb
	begin
		fMask_next = fMask_reg;
		if (wrOk && regAddr == `AMP_OFS_FAULT_MASK)
			fMask_next = regWrData[3:0];
		rampCnt_next = (!standbyPinN && oscEnable) ? rampCnt_reg + 1 : 0;
	end
	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fMask_reg <= 4'h0;
			rampCnt_reg <= 0;
		end
		else
		begin
			fMask_reg <= fMask_next;
			rampCnt_reg <= rampCnt_next;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	// port enable one cycle on marks a state that monitors faults
	property p_faultSet;
		(|(cause[3:1] & ~fMask_reg[3:1]) && ctrlPortEnable) ##1 ctrlPortEnable |-> faultPinOe;
	endproperty
	a_faultSet: assert property (p_faultSet) else $error("fault pin idle with fault");
	property p_faultClr;
		cause == 4'h0 |=> !faultPinOe;
	endproperty
	a_faultClr: assert property (p_faultClr) else $error("fault pin held without fault");
	property p_tsdHiZ;
		thermalShutdownEvent && ctrlPortEnable |-> ##[1:3] (&chHiZ);
	endproperty
	a_tsdHiZ: assert property (p_tsdHiZ) else $error("shutdown left outputs driven");
	property p_chanHiZ;
		$rose(chOverCurrent[0] || chDcError[0]) && (outAudio || outMute50) |-> ##[1:3] chHiZ[0];
	endproperty
	a_chanHiZ: assert property (p_chanHiZ) else $error("faulty channel kept driving");
	property p_warnHold;
		warnPinOe && !clrWr |=> warnPinOe;
	endproperty
	a_warnHold: assert property (p_warnHold) else $error("warning pin dropped");
	property p_warnClr;
		clrWr && !porEvent && !overTempWarning && chOverTempWarning == 4'h0 && chMaxMod == 4'h0
			&& $past(chMaxMod) == 4'h0 |=> !warnPinOe;
	endproperty
	a_warnClr: assert property (p_warnClr) else $error("warning pin not cleared");
	property p_porWarn;
		porEvent |=> warnPinOe ##[0:2] !ctrlPortEnable;
	endproperty
	a_porWarn: assert property (p_porWarn) else $error("power-on event not handled");
	property p_mute;
		!mutePinN [*5] |-> !outAudio;
	endproperty
	a_mute: assert property (p_mute) else $error("audio while muted");
	property p_ramp;
		rampCnt_reg <= RAMP_MAX;
	endproperty
	a_ramp: assert property (p_ramp) else $error("shutdown ramp too long");
	property p_standby;
		!oscEnable |-> !ctrlPortEnable && (&chHiZ) && !outAudio && !outMute50;
	endproperty
	a_standby: assert property (p_standby) else $error("standby state outputs wrong");
	property p_mode;
		(ctrlPortEnable || outMute50 || outAudio) |-> oscEnable && !(outMute50 && outAudio);
	endproperty
	a_mode: assert property (p_mode) else $error("mode outputs inconsistent");
	property p_thresh;
		logic [1:0] v;
		(wrOk && regAddr == `AMP_OFS_MISC_CTRL1, v = regWrData[6:5]) |=> otwThreshold == v;
	endproperty
	a_thresh: assert property (p_thresh) else $error("threshold field not applied");
	c_clear: cover property (clrWr && warnPinOe);
	c_standby: cover property ($fell(oscEnable));
	c_fault: cover property (faultPinOe && outAudio);
endmodule

bind amp_status_ctrl amp_status_ctrl_props #(.RAMP_CYCLES(RAMP_CYCLES)) amp_status_ctrl_props_inst (.clk_sys,
	.sys_rst, .mutePinN, .standbyPinN, .faultPinOe, .warnPinOe, .chOverCurrent, .chDcError, .chOverTempWarning,
	.chMaxMod, .overTempWarning, .thermalShutdownEvent, .lowSupplyEvent, .highSupplyEvent, .clockError,
	.porEvent, .regWr, .regAddr, .regWrData, .chHiZ, .outMute50, .outAudio, .oscEnable, .ctrlPortEnable,
	.otwThreshold);
`default_nettype wire
